//--- hw/ssync_pkg.sv
// Purpose: Constants for the synchronous slave serial port.
// Assumes: 32-bit APB, one register per aligned word.
// Notes:   Field positions follow the control register layout.
package ssync_pkg;

  // ************************************************
  // Register byte addresses
  // ************************************************
  localparam logic [7:0] A_TSC  = 8'h00;
  localparam logic [7:0] A_RSC  = 8'h04;
  localparam logic [7:0] A_BAUD = 8'h08;
  localparam logic [7:0] A_INTC = 8'h0C;
  localparam logic [7:0] A_PIE  = 8'h10;
  localparam logic [7:0] A_PIR  = 8'h14;
  localparam logic [7:0] A_RCV  = 8'h18;
  localparam logic [7:0] A_THR  = 8'h1C;
  localparam logic [7:0] A_APS  = 8'h20;

  // ************************************************
  // Field positions and writable masks
  // ************************************************
  localparam int B_CLOCK_SOURCE_MASTER_SELECT  = 7;
  localparam int B_TXEN  = 5;
  localparam int B_SYNC  = 4;
  localparam int B_TRMT  = 1;
  localparam int B_SERIAL_PORT_ENABLE  = 7;
  localparam int B_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int B_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int B_OERR  = 1;
  localparam int B_RCIDL = 6;
  localparam int B_SCKP  = 4;
  localparam int B_GIE   = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE  = 6;
  localparam int B_RCI   = 5;
  localparam int B_TXI   = 4;
  localparam int B_RXSEL = 7;
  localparam int B_CKSEL = 2;
  localparam logic [7:0] M_TSC  = 8'hB0;
  localparam logic [7:0] M_RSC  = 8'hB0;
  localparam logic [7:0] M_BAUD = 8'h10;
  localparam logic [7:0] M_INTC = 8'hC0;
  localparam logic [7:0] M_PIE  = 8'h30;
  localparam logic [7:0] M_APS  = 8'h84;
  localparam logic [7:0] R_ZERO = 8'h00;

  // Interrupt vector taken after a serial wake
  localparam logic [11:0] IRQ_VECTOR = 12'h004;

  // Transmit sequencer states, Gray coded
  typedef enum logic [1:0] {
    SS_TX_IDLE  = 2'b00,
    SS_TX_SHIFT = 2'b01
  } ssync_tx_t;

endpackage : ssync_pkg

//--- hw/ssync_slave.sv
// Purpose: Synchronous slave serial port that keeps shifting in sleep.
// Assumes: Shift clock and data arrive from an external master.
// Notes:   Pin inputs pass two flip-flops before use.
module ssync_slave
  import ssync_pkg::*;
#(
  parameter int unsigned WORD_BITS = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleep_active,
  input  wire logic        ck_pin_a_i,
  input  wire logic        ck_pin_b_i,
  input  wire logic        dt_pin_a_i,
  input  wire logic        dt_pin_b_i,
  output logic             dt_pin_a_o,
  output logic             dt_pin_a_oe_n,
  output logic             dt_pin_b_o,
  output logic             dt_pin_b_oe_n,
  output logic             wake_req,
  output logic             vector_req,
  output logic      [11:0] vector_addr
);

  localparam int CW = $clog2(WORD_BITS + 1);
  localparam logic [CW-1:0] LAST = CW'(WORD_BITS - 1);

  // ************************************************
  // Register bus
  // ************************************************
  logic [7:0]  tsc_q, tsc_d, rsc_q, rsc_d;
  logic [7:0]  baud_q, baud_d, intc_q, intc_d;
  logic [7:0]  pie_q, pie_d, aps_q, aps_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        acc, wr, rd_rcv, wr_thr, hit;
  logic [7:0]  rdv;
  logic        receive_flag_q, transmit_flag_q, oerr_q, rx_idle;
  logic        trmt;
  logic [WORD_BITS-1:0] rcv_q;

  // Access phase completes on the cycle after setup
  assign acc    = psel & penable & pready_q;
  assign wr     = acc & pwrite;
  assign rd_rcv = acc & ~pwrite & (paddr == A_RCV);
  assign wr_thr = wr & (paddr == A_THR);

  // Read mux and address decode
  always_comb begin
    hit = 1'b1;
    rdv = R_ZERO;
    unique case (paddr)
      A_TSC:  rdv = tsc_q | {6'h00, trmt, 1'b0};
      A_RSC:  rdv = rsc_q | {6'h00, oerr_q, 1'b0};
      A_BAUD: rdv = baud_q | {1'b0, rx_idle, 6'h00};
      A_INTC: rdv = intc_q;
      A_PIE:  rdv = pie_q;
      A_PIR:  rdv = {2'h0, receive_flag_q, transmit_flag_q, 4'h0};
      A_RCV:  rdv = 8'(rcv_q);
      A_THR:  rdv = R_ZERO;
      A_APS:  rdv = aps_q;
      default: hit = 1'b0;
    endcase
  end

  // Next values for bus answer and writable fields
  always_comb begin
    tsc_d     = tsc_q;
    rsc_d     = rsc_q;
    baud_d    = baud_q;
    intc_d    = intc_q;
    pie_d     = pie_q;
    aps_d     = aps_q;
    pready_d  = psel & ~penable;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel & ~penable) begin
      prdata_d  = pwrite ? 32'h0000_0000 : {24'h00_0000, rdv};
      pslverr_d = ~hit;
    end
    if (wr) begin
      unique case (paddr)
        A_TSC:  tsc_d  = pwdata[7:0] & M_TSC;
        A_RSC:  rsc_d  = pwdata[7:0] & M_RSC;
        A_BAUD: baud_d = pwdata[7:0] & M_BAUD;
        A_INTC: intc_d = pwdata[7:0] & M_INTC;
        A_PIE:  pie_d  = pwdata[7:0] & M_PIE;
        A_APS:  aps_d  = pwdata[7:0] & M_APS;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tsc_q     <= R_ZERO;
      rsc_q     <= R_ZERO;
      baud_q    <= R_ZERO;
      intc_q    <= R_ZERO;
      pie_q     <= R_ZERO;
      aps_q     <= R_ZERO;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      tsc_q     <= tsc_d;
      rsc_q     <= rsc_d;
      baud_q    <= baud_d;
      intc_q    <= intc_d;
      pie_q     <= pie_d;
      aps_q     <= aps_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ************************************************
  // Mode decode and pin synchronisers
  // ************************************************
  logic slave, tx_dir, rx_en, tx_go;
  logic ck_raw, dt_raw;
  logic [1:0] ck_s_q, ck_s_d, dt_s_q, dt_s_d;
  logic ck_d_q, ck_d_d;
  logic smp_edge, drv_edge, ck_eff, ck_prev;

  // Only the external clock can run the shifters, so
  // every non-slave mode is simply idle here
  assign slave = tsc_q[B_SYNC] & ~tsc_q[B_CLOCK_SOURCE_MASTER_SELECT] &
                 rsc_q[B_SERIAL_PORT_ENABLE];
  assign tx_dir = ~rsc_q[B_SINGLE_RECEIVE_ENABLE] & ~rsc_q[B_CONTINUOUS_RECEIVE_ENABLE];
  assign rx_en  = slave & ~tx_dir;
  assign tx_go  = slave & tx_dir & tsc_q[B_TXEN];

  // Pin position picked before the synchroniser
  assign ck_raw = aps_q[B_CKSEL] ? ck_pin_b_i
                                 : ck_pin_a_i;
  assign dt_raw = aps_q[B_RXSEL] ? dt_pin_b_i
                                 : dt_pin_a_i;

  always_comb begin
    ck_s_d = {ck_s_q[0], ck_raw};
    dt_s_d = {dt_s_q[0], dt_raw};
    ck_d_d = ck_s_q[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_s_q <= 2'b00;
      dt_s_q <= 2'b00;
      ck_d_q <= 1'b0;
    end else begin
      ck_s_q <= ck_s_d;
      dt_s_q <= dt_s_d;
      ck_d_q <= ck_d_d;
    end
  end

  // Polarity bit flips which edge samples and which drives
  assign ck_eff   = ck_s_q[1] ^ baud_q[B_SCKP];
  assign ck_prev  = ck_d_q ^ baud_q[B_SCKP];
  assign smp_edge = ck_eff & ~ck_prev;
  assign drv_edge = ~ck_eff & ck_prev;

  // ************************************************
  // Transmit path
  // ************************************************
  ssync_tx_t tx_st_q, tx_st_d;
  logic [WORD_BITS-1:0] tsr_q, tsr_d, thr_q, thr_d;
  logic [CW-1:0] tcnt_q, tcnt_d;
  logic hold_q, hold_d, transmit_flag_d, tx_done;
  logic dt_o_q, dt_o_d, oe_a_q, oe_a_d, oe_b_q, oe_b_d;

  assign tx_done = (tx_st_q == SS_TX_SHIFT) & drv_edge &
                   (tcnt_q == LAST);
  assign trmt = (tx_st_q == SS_TX_IDLE);

  // Shifter, holding buffer and the flag that mirrors it
  always_comb begin
    tx_st_d = tx_st_q;
    tsr_d   = tsr_q;
    thr_d   = thr_q;
    tcnt_d  = tcnt_q;
    hold_d  = hold_q;
    unique case (tx_st_q)
      SS_TX_IDLE: begin
        if (tx_go & hold_q) begin
          tsr_d   = thr_q;
          hold_d  = 1'b0;
          tcnt_d  = '0;
          tx_st_d = SS_TX_SHIFT;
        end
      end
      SS_TX_SHIFT: begin
        if (~tx_go) begin
          tx_st_d = SS_TX_IDLE;
        end else if (tx_done & hold_q) begin
          tsr_d  = thr_q;
          hold_d = 1'b0;
          tcnt_d = '0;
        end else if (tx_done) begin
          tx_st_d = SS_TX_IDLE;
        end else if (drv_edge) begin
          tsr_d  = tsr_q >> 1;
          tcnt_d = tcnt_q + CW'(1);
        end
      end
    endcase
    // A fresh write goes straight in when the shifter is free
    if (wr_thr) begin
      if (tx_st_d == SS_TX_IDLE && !hold_d && tx_go) begin
        tsr_d   = pwdata[WORD_BITS-1:0];
        tcnt_d  = '0;
        tx_st_d = SS_TX_SHIFT;
      end else begin
        thr_d  = pwdata[WORD_BITS-1:0];
        hold_d = 1'b1;
      end
    end
    transmit_flag_d = ~hold_d;
    dt_o_d = tsr_d[0];
    oe_a_d = ~(tx_go & ~aps_q[B_RXSEL]);
    oe_b_d = ~(tx_go & aps_q[B_RXSEL]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= SS_TX_IDLE;
      tsr_q   <= '0;
      thr_q   <= '0;
      tcnt_q  <= '0;
      hold_q  <= 1'b0;
      transmit_flag_q  <= 1'b1;
      dt_o_q  <= 1'b0;
      oe_a_q  <= 1'b1;
      oe_b_q  <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tsr_q   <= tsr_d;
      thr_q   <= thr_d;
      tcnt_q  <= tcnt_d;
      hold_q  <= hold_d;
      transmit_flag_q  <= transmit_flag_d;
      dt_o_q  <= dt_o_d;
      oe_a_q  <= oe_a_d;
      oe_b_q  <= oe_b_d;
    end
  end

  assign dt_pin_a_o    = dt_o_q;
  assign dt_pin_b_o    = dt_o_q;
  assign dt_pin_a_oe_n = oe_a_q;
  assign dt_pin_b_oe_n = oe_b_q;

  // ************************************************
  // Receive path
  // ************************************************
  logic [WORD_BITS-1:0] rsr_q, rsr_d, rcv_d, rsr_nx;
  logic [CW-1:0] rcnt_q, rcnt_d;
  logic receive_flag_d, oerr_d, rx_word;

  assign rsr_nx  = {dt_s_q[1], rsr_q[WORD_BITS-1:1]};
  assign rx_word = rx_en & smp_edge & (rcnt_q == LAST);
  assign rx_idle = (rcnt_q == '0);

  // New word beats a same-cycle read so no flag is lost
  always_comb begin
    rsr_d  = rsr_q;
    rcnt_d = rcnt_q;
    rcv_d  = rcv_q;
    receive_flag_d = receive_flag_q & ~rd_rcv;
    oerr_d = oerr_q & rsc_q[B_CONTINUOUS_RECEIVE_ENABLE] & rsc_q[B_SERIAL_PORT_ENABLE];
    if (!rx_en) begin
      rcnt_d = '0;
    end else if (smp_edge) begin
      rsr_d  = rsr_nx;
      rcnt_d = rx_word ? '0 : rcnt_q + CW'(1);
    end
    if (rx_word) begin
      if (receive_flag_q & ~rd_rcv) begin
        oerr_d = 1'b1; // older word kept on overrun
      end else begin
        rcv_d  = rsr_nx;
        receive_flag_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsr_q  <= '0;
      rcnt_q <= '0;
      rcv_q  <= '0;
      receive_flag_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      rsr_q  <= rsr_d;
      rcnt_q <= rcnt_d;
      rcv_q  <= rcv_d;
      receive_flag_q <= receive_flag_d;
      oerr_q <= oerr_d;
    end
  end

  // ************************************************
  // Wake and vector request
  // ************************************************
  logic wake_q, wake_d, vreq_q, vreq_d, ev;
  logic [11:0] vadr_q, vadr_d;

  // Both flags share the peripheral enable gate
  assign ev = intc_q[B_PERIPHERAL_IRQ_ENABLE] &
              ((receive_flag_q & pie_q[B_RCI]) |
               (transmit_flag_q & pie_q[B_TXI]));

  always_comb begin
    wake_d = sleep_active & ev;
    vreq_d = ev & intc_q[B_GIE];
    vadr_d = vreq_d ? IRQ_VECTOR : 12'h000;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b0;
      vreq_q <= 1'b0;
      vadr_q <= 12'h000;
    end else begin
      wake_q <= wake_d;
      vreq_q <= vreq_d;
      vadr_q <= vadr_d;
    end
  end

  assign wake_req    = wake_q;
  assign vector_req  = vreq_q;
  assign vector_addr = vadr_q;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_last_bit_out;
    tx_done && hold_q && tx_go;
  endsequence
  sequence s_reloaded;
    (tx_st_q == SS_TX_SHIFT) && !hold_q && transmit_flag_q;
  endsequence

  property p_reload;
    s_last_bit_out and !wr_thr |=> s_reloaded;
  endproperty
  a_reload: assert property (p_reload)
    else $error("holding byte not reloaded");

  property p_rd_clear;
    rd_rcv && !rx_word |=> !receive_flag_q;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read left receive flag set");

  property p_word_flag;
    rx_word |=> receive_flag_q;
  endproperty
  a_word_flag: assert property (p_word_flag)
    else $error("word done without receive flag");

  property p_wake;
    sleep_active && receive_flag_q && pie_q[B_RCI] &&
      intc_q[B_PERIPHERAL_IRQ_ENABLE] |=> wake_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on receive flag");

  property p_tx_wake_gate;
    wake_q |-> $past(intc_q[B_PERIPHERAL_IRQ_ENABLE]) &&
      $past((transmit_flag_q && pie_q[B_TXI]) ||
            (receive_flag_q && pie_q[B_RCI]));
  endproperty
  a_tx_wake_gate: assert property (p_tx_wake_gate)
    else $error("wake without enables");

  // A write that goes straight into a free shifter leaves the
  // holding buffer empty, so only a write behind a busy shifter
  // is bound to clear the flag
  property p_thr_clear;
    wr_thr && !trmt && !tx_done |=> !transmit_flag_q;
  endproperty
  a_thr_clear: assert property (p_thr_clear)
    else $error("write left transmit flag set");

  property p_ext_clock;
    $changed(rsr_q) |-> $past(smp_edge && rx_en);
  endproperty
  a_ext_clock: assert property (p_ext_clock)
    else $error("receive shift without clock edge");

  property p_vector;
    vector_req |-> vector_addr == IRQ_VECTOR &&
                   $past(intc_q[B_GIE]);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector request malformed");

  property p_idle_mode;
    !slave ##1 !slave |-> dt_pin_a_oe_n && dt_pin_b_oe_n
                          && rx_idle;
  endproperty
  a_idle_mode: assert property (p_idle_mode)
    else $error("shifting outside slave mode");

  property p_drive_bit;
    tx_go && !wr_thr |=> dt_pin_a_o == $past(tsr_d[0]);
  endproperty
  a_drive_bit: assert property (p_drive_bit)
    else $error("data pin not tracking shifter");

endmodule : ssync_slave

//--- bench/ssync_master_model.sv
// Purpose: External synchronous master that clocks the slave link.
// Assumes: Clock idles low; slave samples on rise, shifts on fall.
// Notes:   A released data line shows the inverse of its last bit.
module ssync_master_model (
  input  wire logic alt,
  input  wire logic line_a,
  input  wire logic line_b,
  output logic      ck_a,
  output logic      ck_b,
  output logic      dt_a,
  output logic      dt_b
);
  timeunit 1ns;
  timeprecision 100ps;

  logic ck;
  logic dt;

  // Clock runs only on the selected pin, so a wrong pin sees no edges
  assign ck_a = alt ? 1'b0 : ck;
  assign ck_b = alt ? ck : 1'b0;
  // Unselected data pin carries the opposite level
  assign dt_a = alt ? ~dt : dt;
  assign dt_b = alt ? dt : ~dt;

  initial begin
    ck = 1'b0;
    dt = 1'b0;
  end

  // One full-duplex word, LSB first, 125 ns per bit; clock stops after
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      dt = tx[i];
      #62.5 ck = 1'b1;
      rx[i] = alt ? line_b : line_a;
      #62.5 ck = 1'b0;
    end
    dt = ~dt;
    #500;
  endtask : xfer
endmodule : ssync_master_model

//--- bench/tb_serial_sync_slave_sleep_ops.sv
// Purpose: Self-checking bench for the sleeping synchronous slave port.
// Assumes: Registers on APB; an external master clocks the link.
// Notes:   Frames stop between words, so flags settle before checks.
`define CHK(g, x) chk(32'(g), 32'(x))
module tb_serial_sync_slave_sleep_ops
  import ssync_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] x;
    logic       e;
  } ssync_row_t;

  logic        clk, rst, psel, penable, pwrite, sleep_active;
  logic [7:0]  paddr, rx;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, wake_req, vector_req, e, alt;
  logic [11:0] vector_addr;
  logic        ck_a, ck_b, md_a, md_b, do_a, do_b, oe_a_n, oe_b_n;
  logic        line_a, line_b;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // Register access table: reset values, masks, read-only, unmapped
  localparam ssync_row_t ROWS [13] = '{
    '{1'b0, A_PIR,  8'h00, 8'h10, 1'b0},
    '{1'b0, A_RSC,  8'h00, 8'h00, 1'b0},
    '{1'b0, A_TSC,  8'h00, 8'h02, 1'b0},
    '{1'b1, A_INTC, 8'hFF, 8'h00, 1'b0},
    '{1'b0, A_INTC, 8'h00, 8'hC0, 1'b0},
    '{1'b1, A_PIE,  8'hFF, 8'h00, 1'b0},
    '{1'b0, A_PIE,  8'h00, 8'h30, 1'b0},
    '{1'b1, A_APS,  8'hFF, 8'h00, 1'b0},
    '{1'b0, A_APS,  8'h00, 8'h84, 1'b0},
    '{1'b1, A_PIR,  8'hEF, 8'h00, 1'b0},
    '{1'b0, A_PIR,  8'h00, 8'h10, 1'b0},
    '{1'b0, 8'h24,  8'h00, 8'h00, 1'b1},
    '{1'b1, 8'h28,  8'hFF, 8'h00, 1'b1}
  };

  // Wire level: the device wins while its enable is low
  assign line_a = oe_a_n ? md_a : do_a;
  assign line_b = oe_b_n ? md_b : do_b;

  ssync_slave ssync_slave_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_active(sleep_active),
    .ck_pin_a_i(ck_a), .ck_pin_b_i(ck_b),
    .dt_pin_a_i(line_a), .dt_pin_b_i(line_b),
    .dt_pin_a_o(do_a), .dt_pin_a_oe_n(oe_a_n),
    .dt_pin_b_o(do_b), .dt_pin_b_oe_n(oe_b_n),
    .wake_req(wake_req), .vector_req(vector_req),
    .vector_addr(vector_addr)
  );

  ssync_master_model ssync_master_model_i (
    .alt(alt), .line_a(line_a), .line_b(line_b),
    .ck_a(ck_a), .ck_b(ck_b), .dt_a(md_a), .dt_b(md_b)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard well above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    samples_checked++;
    if (got !== x) begin
      num_errors++;
      $display("FAIL %0t got %0h expected %0h", $time, got, x);
    end
  endtask : chk

  // One APB transfer; waits for pready, holding the request meanwhile
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h00000000, r, e);
    `CHK(r, {24'h000000, x});
  endtask : rdchk

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    sleep_active = 1'b0;
    alt = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `CHK({pready, pslverr, oe_a_n, oe_b_n, wake_req, vector_req}, 6'h0C);
    `CHK(vector_addr, 12'h000);
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, {24'h000000, ROWS[i].d}, r, e);
      `CHK(e, ROWS[i].e);
      if (!ROWS[i].w) `CHK(r, {24'h000000, ROWS[i].x});
    end
    // Receive a word while asleep, wake and vector, then unload it
    wr(A_APS, 8'h00);
    wr(A_TSC, 8'h10);
    wr(A_RSC, 8'h90);
    wr(A_PIE, 8'h20);
    apb(1'b0, A_RCV, 32'h00000000, r, e);
    @(posedge clk) sleep_active <= 1'b1;
    ssync_master_model_i.xfer(8'hA5, rx);
    `CHK(wake_req, 1'b1);
    `CHK({vector_req, vector_addr}, 13'h1004);
    @(posedge clk) sleep_active <= 1'b0;
    rdchk(A_PIR, 8'h30);
    rdchk(A_RCV, 8'hA5);
    rdchk(A_PIR, 8'h10);
    // Another word, 3C, over the alternate pins; device never drives in receive
    wr(A_APS, 8'h84);
    alt <= 1'b1;
    ssync_master_model_i.xfer(8'h3C, rx);
    `CHK({oe_a_n, oe_b_n}, 2'b11);
    rdchk(A_RCV, 8'h3C);
    wr(A_APS, 8'h00);
    alt <= 1'b0;
    // Master and asynchronous modes must not shift during sleep
    for (int m = 0; m < 2; m++) begin
      wr(A_TSC, m ? 8'h00 : 8'h90);
      @(posedge clk) sleep_active <= 1'b1;
      ssync_master_model_i.xfer(8'hFF, rx);
      `CHK(wake_req, 1'b0);
      @(posedge clk) sleep_active <= 1'b0;
      rdchk(A_PIR, 8'h10);
    end
    // Two words queued before sleep; reload sets flag and wakes
    wr(A_TSC, 8'h30);
    wr(A_RSC, 8'h80);
    wr(A_PIE, 8'h10);
    wr(A_INTC, 8'h40);
    wr(A_THR, 8'h5A);
    wr(A_THR, 8'hC3);
    rdchk(A_PIR, 8'h00);
    `CHK({oe_a_n, do_a}, 2'b00);
    @(posedge clk) sleep_active <= 1'b1;
    ssync_master_model_i.xfer(8'h00, rx);
    `CHK(rx, 8'h5A);
    `CHK({wake_req, vector_req}, 2'b10);
    @(posedge clk) sleep_active <= 1'b0;
    rdchk(A_PIR, 8'h10);
    wr(A_THR, 8'h0F);
    rdchk(A_PIR, 8'h00);
    ssync_master_model_i.xfer(8'h00, rx);
    `CHK(rx, 8'hC3);
    // Without the transmit interrupt enable the empty holding flag must not wake
    wr(A_PIE, 8'h00);
    @(posedge clk) sleep_active <= 1'b1;
    ssync_master_model_i.xfer(8'h00, rx);
    `CHK(rx, 8'h0F);
    `CHK(wake_req, 1'b0);
    results();
  end
endmodule : tb_serial_sync_slave_sleep_ops
